// file: shared/tmcr_pkg.sv
`default_nettype none
package tmcr_pkg;
    // ----------------------------------------
    // serial frame and addresses
    // ----------------------------------------
    localparam int FRAME_BITS = 24;
    localparam int DATA_MSB = 19;
    localparam int DATA_LSB = 4;
    localparam logic [4:0] FRAME_CNT = 5'h18;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    localparam logic [3:0] ADDR_RF_MAIN = 4'h0;
    localparam logic [3:0] ADDR_RF_REF = 4'h1;
    localparam logic [3:0] ADDR_OPER = 4'h4;
    localparam logic [3:0] ADDR_CONF = 4'h5;
    localparam logic [15:0] OPER_RST = 16'h090F;
    localparam logic [15:0] CONF_RST = 16'hD03F;
    // ----------------------------------------
    // operation_control fields
    // ----------------------------------------
    localparam int OB_LO_PORT = 15;
    localparam int OB_RFB_HI = 14;
    localparam int OB_IFB_HOLD = 13;
    localparam int OB_MODE_HI = 12;
    localparam int OB_MODE_LO = 11;
    localparam int OB_IF_PORT = 10;
    localparam int OB_OSC_BAND = 9;
    localparam int OB_GAIN_HI = 8;
    localparam int OB_GAIN_LO = 6;
    localparam int OB_SIDE = 5;
    localparam int OB_LOBUF = 4;
    localparam int OB_MODK = 3;
    localparam int OB_STANDBY = 2;
    localparam int OB_TXSLEEP = 1;
    localparam int OB_PWRDN = 0;
    // ----------------------------------------
    // configuration_setup fields
    // ----------------------------------------
    localparam int CB_IF_SYN = 15;
    localparam int CB_RF_SYN = 14;
    localparam int CB_EXT_OSC = 10;
    localparam int CB_IFI_HI = 9;
    localparam int CB_IFI_LO = 8;
    localparam int CB_RFI_HI = 7;
    localparam int CB_RFI_LO = 6;
    localparam int CB_IF_POL = 5;
    localparam int CB_RF_POL = 4;
    localparam int CB_IFB_EN = 3;
    localparam int CB_RFB_LO = 2;
    localparam int CB_LOCK_HI = 1;
    localparam int CB_LOCK_LO = 0;
    // ----------------------------------------
    // codes
    // ----------------------------------------
    localparam logic [1:0] MODE_FM = 2'h0;
    localparam logic [1:0] MODE_CELL = 2'h1;
    localparam logic [1:0] MODE_PCS_LOW = 2'h2;
    localparam logic [1:0] MODE_PCS_UP = 2'h3;
    localparam logic [2:0] RFO_LOW = 3'h1;
    localparam logic [2:0] RFO_HIGH1 = 3'h2;
    localparam logic [2:0] RFO_HIGH0 = 3'h4;
    localparam logic [1:0] BOOST_NONE = 2'h0;
    localparam logic [1:0] BOOST_REPROG = 2'h1;
    localparam logic [1:0] BOOST_ALWAYS = 2'h2;
    localparam logic [1:0] BOOST_UNLOCK = 2'h3;
    localparam logic [1:0] LOCK_IF = 2'h1;
    localparam logic [1:0] LOCK_RF = 2'h2;
    localparam logic [1:0] LOCK_BOTH = 2'h3;
    // ----------------------------------------
    // synchroniser bit slots
    // ----------------------------------------
    localparam int SYNC_W = 7;
    localparam int SI_SCLK = 0;
    localparam int SI_SDATA = 1;
    localparam int SI_CS = 2;
    localparam int SI_IFLOCK = 3;
    localparam int SI_RFLOCK = 4;
    localparam int SI_SHUTDOWN_PIN = 5;
    localparam int SI_TRANSMIT_GATE_PIN = 6;
    localparam logic [6:0] SYNC_RST = 7'h64;
    typedef enum logic [1:0] {RB_IDLE = 2'b01, RB_ACQ = 2'b10} tmcr_boost_t;
endpackage
`default_nettype wire

// file: rtl/tmcr_regs.sv
// Contract
// - bit 15 picks low or high LO port
// - bit 14 is the high RF boost bit
// - bit 13 holds IF boost after lock
// - bits 12:11 pick mode and RF output
// - bit 10 picks high or low IF pair
// - bit 9 picks high or low IF oscillator
// - bits 8:6 set IF gain steps
// - bit 5 picks upper or lower sideband
// - bit 4 switches IF LO buffer
// - bit 3 picks direct or quadrature modulation
// - standby bit low powers down all sections
// - tx sleep low stops modulator, upconverter
// - power-down bit low stops all, keeps registers
// - config bit 15 enables IF synthesizer
// - config bit 14 enables RF synthesizer
// - config bit 10 selects external oscillator
// - bits 9:8 set IF pump current
// - bits 7:6 set RF pump current
// - bits 5 and 4 set detector polarities
// - config bit 3 boosts IF during acquisition
// - bits 1:0 choose lock pin source
// - two RF boost bits choose boost mode
// - serial writes work during shutdown
`default_nettype none
module tmcr_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // three-wire serial bus
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_cs_n,
    // control pins and lock detectors
    input wire logic shutdown_pin_n,
    input wire logic transmit_gate_pin_n,
    input wire logic if_lock,
    input wire logic rf_lock,
    // port and band selection
    output logic lo_port_select_r,
    output logic [2:0] rf_out_sel_r,
    output logic fm_mode_r,
    output logic if_port_select_r,
    output logic if_osc_band_select_r,
    output logic [2:0] if_gain_step_r,
    output logic image_side_select_r,
    output logic lo_buffer_on_r,
    output logic modulation_kind_r,
    // section enables
    output logic modulator_on_r,
    output logic upconverter_on_r,
    output logic if_synth_on_r,
    output logic rf_synth_on_r,
    output logic if_osc_on_r,
    output logic ext_osc_buf_on_r,
    // synthesizer settings
    output logic [1:0] if_pump_current_r,
    output logic [1:0] rf_pump_current_r,
    output logic if_detector_polarity_r,
    output logic rf_detector_polarity_r,
    output logic if_pump_boost_r,
    output logic rf_pump_boost_r,
    output logic lock_pin_r
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // mode code to one-hot RF output
    function automatic logic [2:0] rf_out_dec(input logic [1:0] m);
        case (m)
            tmcr_pkg::MODE_PCS_LOW: rf_out_dec = tmcr_pkg::RFO_HIGH1;
            tmcr_pkg::MODE_PCS_UP: rf_out_dec = tmcr_pkg::RFO_HIGH0;
            default: rf_out_dec = tmcr_pkg::RFO_LOW;
        endcase
    endfunction

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [tmcr_pkg::SYNC_W-1:0] sync1_r;
    logic [tmcr_pkg::SYNC_W-1:0] sync2_r;
    logic sclk_prev_r;
    logic cs_prev_r;
    logic [tmcr_pkg::FRAME_BITS-1:0] shift_r;
    logic [4:0] cnt_r;
    logic [15:0] op_r;
    logic [15:0] cfg_r;
    logic rf_reprog_r;
    tmcr_pkg::tmcr_boost_t rb_state_r;

    // every pin is async to core_clk; idle-high pins reset high
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_r <= tmcr_pkg::SYNC_RST;
            sync2_r <= tmcr_pkg::SYNC_RST;
        end else begin
            sync1_r <= {transmit_gate_pin_n, shutdown_pin_n, rf_lock, if_lock, ser_cs_n, ser_data, ser_clk};
            sync2_r <= sync1_r;
        end
    end

    logic sclk_s;
    logic sdata_s;
    logic cs_n_s;
    logic if_lock_s;
    logic rf_lock_s;
    logic shutdown_pin_n_s;
    logic transmit_gate_pin_n_s;
    assign sclk_s = sync2_r[tmcr_pkg::SI_SCLK];
    assign sdata_s = sync2_r[tmcr_pkg::SI_SDATA];
    assign cs_n_s = sync2_r[tmcr_pkg::SI_CS];
    assign if_lock_s = sync2_r[tmcr_pkg::SI_IFLOCK];
    assign rf_lock_s = sync2_r[tmcr_pkg::SI_RFLOCK];
    assign shutdown_pin_n_s = sync2_r[tmcr_pkg::SI_SHUTDOWN_PIN];
    assign transmit_gate_pin_n_s = sync2_r[tmcr_pkg::SI_TRANSMIT_GATE_PIN];

    // ----------------------------------------
    // serial shifter
    // ----------------------------------------
    // edge history taken from the second stage only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_prev_r <= 1'b0;
            cs_prev_r <= 1'b1;
        end else begin
            sclk_prev_r <= sclk_s;
            cs_prev_r <= cs_n_s;
        end
    end

    logic sclk_rise;
    logic cs_rise;
    logic frame_ok;
    logic [3:0] frame_addr;
    logic [15:0] frame_data;
    logic wr_op;
    logic wr_cfg;
    assign sclk_rise = sclk_s & ~sclk_prev_r;
    assign cs_rise = cs_n_s & ~cs_prev_r;
    assign frame_ok = cs_rise && (cnt_r == tmcr_pkg::FRAME_CNT);
    assign frame_addr = shift_r[3:0];
    assign frame_data = shift_r[tmcr_pkg::DATA_MSB:tmcr_pkg::DATA_LSB];
    assign wr_op = frame_ok && (frame_addr == tmcr_pkg::ADDR_OPER);
    assign wr_cfg = frame_ok && (frame_addr == tmcr_pkg::ADDR_CONF);

    // msb first while select is low; count saturates so long frames fail
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shift_r <= '0;
            cnt_r <= '0;
        end else if (cs_n_s) begin
            cnt_r <= '0;
        end else if (sclk_rise) begin
            shift_r <= {shift_r[tmcr_pkg::FRAME_BITS-2:0], sdata_s};
            if (cnt_r != tmcr_pkg::CNT_MAX) begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // shutdown never gates the load path, so writes land in any power state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op_r <= tmcr_pkg::OPER_RST;
            cfg_r <= tmcr_pkg::CONF_RST;
        end else begin
            if (wr_op) begin
                op_r <= frame_data;
            end
            if (wr_cfg) begin
                cfg_r <= frame_data;
            end
        end
    end

    // a write to either RF divider counts as a synthesizer reprogram
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rf_reprog_r <= 1'b0;
        end else begin
            rf_reprog_r <= frame_ok && (frame_addr == tmcr_pkg::ADDR_RF_MAIN || frame_addr == tmcr_pkg::ADDR_RF_REF);
        end
    end

    // ----------------------------------------
    // power sequencing terms
    // ----------------------------------------
    logic run;
    logic tx_run;
    logic if_run;
    logic rf_run;
    logic [1:0] rf_boost_mode;
    assign run = op_r[tmcr_pkg::OB_PWRDN] & shutdown_pin_n_s & op_r[tmcr_pkg::OB_STANDBY];
    assign tx_run = run & op_r[tmcr_pkg::OB_TXSLEEP] & transmit_gate_pin_n_s;
    assign if_run = run & cfg_r[tmcr_pkg::CB_IF_SYN];
    assign rf_run = run & cfg_r[tmcr_pkg::CB_RF_SYN];
    assign rf_boost_mode = {op_r[tmcr_pkg::OB_RFB_HI], cfg_r[tmcr_pkg::CB_RFB_LO]};

    // ----------------------------------------
    // RF boost tracking
    // ----------------------------------------
    // acquisition window opens on reprogram, closes on lock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rb_state_r <= tmcr_pkg::RB_IDLE;
        end else begin
            case (rb_state_r)
                tmcr_pkg::RB_IDLE: begin
                    if (rf_reprog_r) begin
                        rb_state_r <= tmcr_pkg::RB_ACQ;
                    end
                end
                tmcr_pkg::RB_ACQ: begin
                    if (rf_lock_s && !rf_reprog_r) begin
                        rb_state_r <= tmcr_pkg::RB_IDLE;
                    end
                end
                default: rb_state_r <= tmcr_pkg::RB_IDLE;
            endcase
        end
    end

    logic rf_boost_nxt;
    logic lock_pin_nxt;
    always_comb begin
        case (rf_boost_mode)
            tmcr_pkg::BOOST_REPROG: rf_boost_nxt = rf_run && (rb_state_r == tmcr_pkg::RB_ACQ);
            tmcr_pkg::BOOST_ALWAYS: rf_boost_nxt = rf_run;
            tmcr_pkg::BOOST_UNLOCK: rf_boost_nxt = rf_run && !rf_lock_s;
            default: rf_boost_nxt = 1'b0;
        endcase
    end

    // test code drives low: no internal test signal to show
    always_comb begin
        case (cfg_r[tmcr_pkg::CB_LOCK_HI:tmcr_pkg::CB_LOCK_LO])
            tmcr_pkg::LOCK_IF: lock_pin_nxt = if_lock_s;
            tmcr_pkg::LOCK_RF: lock_pin_nxt = rf_lock_s;
            tmcr_pkg::LOCK_BOTH: lock_pin_nxt = if_lock_s & rf_lock_s;
            default: lock_pin_nxt = 1'b0;
        endcase
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    // one extra cycle of latency buys glitch-free analog controls
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lo_port_select_r <= 1'b0;
            rf_out_sel_r <= tmcr_pkg::RFO_LOW;
            fm_mode_r <= 1'b0;
            if_port_select_r <= 1'b0;
            if_osc_band_select_r <= 1'b0;
            if_gain_step_r <= 3'h4;
            image_side_select_r <= 1'b0;
            lo_buffer_on_r <= 1'b0;
            modulation_kind_r <= 1'b1;
            modulator_on_r <= 1'b0;
            upconverter_on_r <= 1'b0;
            if_synth_on_r <= 1'b0;
            rf_synth_on_r <= 1'b0;
            if_osc_on_r <= 1'b0;
            ext_osc_buf_on_r <= 1'b0;
            if_pump_current_r <= 2'h0;
            rf_pump_current_r <= 2'h0;
            if_detector_polarity_r <= 1'b1;
            rf_detector_polarity_r <= 1'b1;
            if_pump_boost_r <= 1'b0;
            rf_pump_boost_r <= 1'b0;
            lock_pin_r <= 1'b0;
        end else begin
            lo_port_select_r <= op_r[tmcr_pkg::OB_LO_PORT];
            rf_out_sel_r <= rf_out_dec(op_r[tmcr_pkg::OB_MODE_HI:tmcr_pkg::OB_MODE_LO]);
            fm_mode_r <= op_r[tmcr_pkg::OB_MODE_HI:tmcr_pkg::OB_MODE_LO] == tmcr_pkg::MODE_FM;
            if_port_select_r <= op_r[tmcr_pkg::OB_IF_PORT];
            if_osc_band_select_r <= op_r[tmcr_pkg::OB_OSC_BAND];
            if_gain_step_r <= op_r[tmcr_pkg::OB_GAIN_HI:tmcr_pkg::OB_GAIN_LO];
            image_side_select_r <= op_r[tmcr_pkg::OB_SIDE];
            lo_buffer_on_r <= run & op_r[tmcr_pkg::OB_LOBUF];
            modulation_kind_r <= op_r[tmcr_pkg::OB_MODK];
            modulator_on_r <= tx_run;
            upconverter_on_r <= tx_run;
            if_synth_on_r <= if_run;
            rf_synth_on_r <= rf_run;
            if_osc_on_r <= run & ~cfg_r[tmcr_pkg::CB_EXT_OSC];
            ext_osc_buf_on_r <= run & cfg_r[tmcr_pkg::CB_EXT_OSC];
            if_pump_current_r <= cfg_r[tmcr_pkg::CB_IFI_HI:tmcr_pkg::CB_IFI_LO];
            rf_pump_current_r <= cfg_r[tmcr_pkg::CB_RFI_HI:tmcr_pkg::CB_RFI_LO];
            if_detector_polarity_r <= cfg_r[tmcr_pkg::CB_IF_POL];
            rf_detector_polarity_r <= cfg_r[tmcr_pkg::CB_RF_POL];
            if_pump_boost_r <= if_run & (op_r[tmcr_pkg::OB_IFB_HOLD]
                | (cfg_r[tmcr_pkg::CB_IFB_EN] & ~if_lock_s));
            rf_pump_boost_r <= rf_boost_nxt;
            lock_pin_r <= lock_pin_nxt;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_op_load;
        wr_op ##1 1'b1;
    endsequence
    sequence s_reprog_acq;
        rf_reprog_r ##1 (rb_state_r == tmcr_pkg::RB_ACQ);
    endsequence

    AST_LO_PORT: assert property (s_op_load |=> lo_port_select_r == $past(frame_data[15], 2))
        else $error("lo port select not taken from frame");
    AST_WRITE_IN_SHUTDOWN_PIN: assert property (wr_op && !run |=> op_r == $past(frame_data))
        else $error("write lost during shutdown");
    AST_MODE_DEC: assert property (s_op_load |=> rf_out_sel_r == rf_out_dec($past(frame_data[12:11], 2)))
        else $error("rf output does not follow mode");
    AST_TX_SLEEP: assert property (!op_r[tmcr_pkg::OB_TXSLEEP] |=> !modulator_on_r && !upconverter_on_r)
        else $error("tx path on while asleep");
    AST_STANDBY: assert property (!op_r[tmcr_pkg::OB_STANDBY] |=> !if_synth_on_r && !rf_synth_on_r
        && !if_osc_on_r) else $error("section on in standby");
    AST_PWRDN_KEEP: assert property (!op_r[tmcr_pkg::OB_PWRDN] && !wr_op |=> $stable(op_r) && !rf_synth_on_r)
        else $error("power-down lost state or left synth on");
    AST_RF_ALWAYS: assert property (rf_boost_mode == tmcr_pkg::BOOST_ALWAYS && rf_run |=> rf_pump_boost_r)
        else $error("rf boost missing in always mode");
    AST_RF_REPROG: assert property (s_reprog_acq ##0 (rf_boost_mode == tmcr_pkg::BOOST_REPROG && rf_run)
        |=> rf_pump_boost_r)
        else $error("rf boost missing after reprogram");
    AST_IF_HOLD: assert property (op_r[tmcr_pkg::OB_IFB_HOLD] && if_run |=> if_pump_boost_r)
        else $error("if boost not held");
    AST_LOCK_AND: assert property (cfg_r[1:0] == tmcr_pkg::LOCK_BOTH |=> lock_pin_r
        == $past(if_lock_s & rf_lock_s)) else $error("lock pin not the and of both");
endmodule
`default_nettype wire

// file: verif/tmcr_ctrl_model.sv
`default_nettype none
module tmcr_ctrl_model (
    // three-wire serial bus
    output logic ser_clk,
    output logic ser_data,
    output logic ser_cs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // serial frame driver
    // ----------------------------------------
    // clock rests low between frames, select idles high
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_cs_n = 1'b1;
    end
    // msb first; data flips once released so a stale bit never looks valid
    task automatic send(input logic [31:0] frame, input int nbits);
        ser_cs_n = 1'b0;
        #160;
        for (int i = nbits - 1; i >= 0; i--) begin
            ser_data = frame[i];
            #160 ser_clk = 1'b1;
            #160 ser_clk = 1'b0;
        end
        #160 ser_cs_n = 1'b1;
        ser_data = ~ser_data;
        #400;
    endtask
endmodule
`default_nettype wire

// file: verif/tmcr_regs_test.sv
`default_nettype none
module tmcr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic core_clk, rst, shutdown_pin_n, transmit_gate_pin_n, if_lock, rf_lock;
    wire logic ser_clk, ser_data, ser_cs_n;
    logic lo_port_select_r, fm_mode_r, if_port_select_r, if_osc_band_select_r, image_side_select_r;
    logic lo_buffer_on_r, modulation_kind_r, modulator_on_r, upconverter_on_r, if_synth_on_r;
    logic rf_synth_on_r, if_osc_on_r, ext_osc_buf_on_r, if_detector_polarity_r, rf_detector_polarity_r;
    logic if_pump_boost_r, rf_pump_boost_r, lock_pin_r;
    logic [2:0] rf_out_sel_r, if_gain_step_r;
    logic [1:0] if_pump_current_r, rf_pump_current_r;
    logic [15:0] op, cfg;
    int n_errors = 0;
    int num_checks = 0;
    tmcr_ctrl_model ctl (.ser_clk, .ser_data, .ser_cs_n);
    tmcr_regs DUT (.core_clk, .rst, .ser_clk, .ser_data, .ser_cs_n, .shutdown_pin_n, .transmit_gate_pin_n,
        .if_lock, .rf_lock, .lo_port_select_r, .rf_out_sel_r, .fm_mode_r, .if_port_select_r,
        .if_osc_band_select_r, .if_gain_step_r, .image_side_select_r, .lo_buffer_on_r, .modulation_kind_r,
        .modulator_on_r, .upconverter_on_r, .if_synth_on_r, .rf_synth_on_r, .if_osc_on_r, .ext_osc_buf_on_r,
        .if_pump_current_r, .rf_pump_current_r, .if_detector_polarity_r, .rf_detector_polarity_r,
        .if_pump_boost_r, .rf_pump_boost_r, .lock_pin_r);
    // 25 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chkv(input string what, input logic [2:0] exp, input logic [2:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // pins and frames need 4 edges; 6 leaves margin after the sync flops
    task automatic settle();
        repeat (6) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        ctl.send({12'h000, d, a}, 24);
        settle();
    endtask
    // static fields of the operation word, valid while sections are powered
    task automatic chk_op(input logic [15:0] v);
        chk1("lo_port", v[15], lo_port_select_r);
        chk1("if_port", v[10], if_port_select_r);
        chk1("osc_band", v[9], if_osc_band_select_r);
        chkv("gain", v[8:6], if_gain_step_r);
        chk1("side", v[5], image_side_select_r);
        chk1("lo_buf", v[4], lo_buffer_on_r);
        chk1("mod_kind", v[3], modulation_kind_r);
    endtask
    // hang guard, far beyond the roughly 290 us the tests need
    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        shutdown_pin_n = 1'b1;
        transmit_gate_pin_n = 1'b1;
        if_lock = 1'b1;
        rf_lock = 1'b1;
        repeat (10) @(posedge core_clk);
        #1 rst = 1'b0;
        settle();
        chk_op(tmcr_pkg::OPER_RST);
        chkv("rf_out", 3'h1, rf_out_sel_r);
        chk1("fm", 1'b0, fm_mode_r);
        chkv("if_cur", 3'h0, {1'b0, if_pump_current_r});
        chkv("rf_cur", 3'h0, {1'b0, rf_pump_current_r});
        chk1("if_pol", 1'b1, if_detector_polarity_r);
        chk1("rf_pol", 1'b1, rf_detector_polarity_r);
        chk1("if_syn", 1'b1, if_synth_on_r);
        chk1("rf_syn", 1'b1, rf_synth_on_r);
        chk1("ext_osc", 1'b0, ext_osc_buf_on_r);
        chk1("lock", 1'b1, lock_pin_r);
        chk1("mod_on", 1'b1, modulator_on_r);
        $display("test defaults done");
        // every mode code; the if port bit is kept low for fm
        for (int m = 0; m < 4; m++) begin
            op = {m[1], 2'h0, 2'(m), m[1], m[0], 3'(7 - 2 * m), m[0], 1'b1, m != 0, 3'h7};
            wr(tmcr_pkg::ADDR_OPER, op);
            chk_op(op);
            chk1("fm", m == 0, fm_mode_r);
            if (m != 0) chkv("rf_out", 3'h1 << (m - 1), rf_out_sel_r);
        end
        $display("test modes done");
        // pump currents, polarities, oscillator source and every lock source
        for (int i = 0; i < 4; i++) begin
            cfg = {4'hD, 1'b0, i[0], 2'(i), 2'(3 - i), i[0], i[1], 2'h0, 2'(i)};
            if_lock = 1'b1;
            rf_lock = 1'b0;
            wr(tmcr_pkg::ADDR_CONF, cfg);
            chkv("if_cur", {1'b0, cfg[9:8]}, {1'b0, if_pump_current_r});
            chkv("rf_cur", {1'b0, cfg[7:6]}, {1'b0, rf_pump_current_r});
            chk1("if_pol", cfg[5], if_detector_polarity_r);
            chk1("rf_pol", cfg[4], rf_detector_polarity_r);
            chk1("ext_osc", cfg[10], ext_osc_buf_on_r);
            chk1("if_osc", !cfg[10], if_osc_on_r);
            chk1("lock", i == 1, lock_pin_r);
            if_lock = 1'b0;
            rf_lock = 1'b1;
            settle();
            chk1("lock", i == 2, lock_pin_r);
        end
        if_lock = 1'b1;
        for (int j = 0; j < 4; j++) begin
            wr(tmcr_pkg::ADDR_CONF, {j[1], j[0], 14'h103F});
            chk1("if_syn", j[1], if_synth_on_r);
            chk1("rf_syn", j[0], rf_synth_on_r);
        end
        $display("test config done");
        // power-down, tx sleep and standby bits in turn
        for (int k = 0; k < 3; k++) begin
            wr(tmcr_pkg::ADDR_OPER, tmcr_pkg::OPER_RST ^ (16'h0001 << k));
            chk1("mod_on", 1'b0, modulator_on_r);
            chk1("upc_on", 1'b0, upconverter_on_r);
            chk1("rf_syn", k == 1, rf_synth_on_r);
            chk1("if_osc", k == 1, if_osc_on_r);
        end
        wr(tmcr_pkg::ADDR_OPER, 16'h09CE);
        chkv("gain", 3'h7, if_gain_step_r);
        wr(tmcr_pkg::ADDR_OPER, tmcr_pkg::OPER_RST);
        chk1("mod_on", 1'b1, modulator_on_r);
        shutdown_pin_n = 1'b0;
        settle();
        chk1("rf_syn", 1'b0, rf_synth_on_r);
        wr(tmcr_pkg::ADDR_OPER, 16'h09CF);
        chkv("gain", 3'h7, if_gain_step_r);
        shutdown_pin_n = 1'b1;
        transmit_gate_pin_n = 1'b0;
        settle();
        chk1("mod_on", 1'b0, modulator_on_r);
        chk1("rf_syn", 1'b1, rf_synth_on_r);
        transmit_gate_pin_n = 1'b1;
        $display("test power done");
        // rf boost modes: none, after reprogram, always, while unlocked
        for (int b = 0; b < 4; b++) begin
            wr(tmcr_pkg::ADDR_CONF, {13'h1A07, b[0], 2'h3});
            wr(tmcr_pkg::ADDR_OPER, {1'b0, b[1], 14'h090F});
            chk1("rf_bst", b == 2, rf_pump_boost_r);
            rf_lock = 1'b0;
            if (b == 1) wr(tmcr_pkg::ADDR_RF_MAIN, 16'h1234);
            else settle();
            chk1("rf_bst", b != 0, rf_pump_boost_r);
            rf_lock = 1'b1;
            settle();
            chk1("rf_bst", b == 2, rf_pump_boost_r);
        end
        if_lock = 1'b0;
        settle();
        chk1("if_bst", 1'b1, if_pump_boost_r);
        if_lock = 1'b1;
        settle();
        chk1("if_bst", 1'b0, if_pump_boost_r);
        wr(tmcr_pkg::ADDR_OPER, 16'h290F);
        chk1("if_bst", 1'b1, if_pump_boost_r);
        $display("test boost done");
        // short frame, foreign address and long frame all leave gain alone
        wr(tmcr_pkg::ADDR_OPER, tmcr_pkg::OPER_RST);
        for (int n = 0; n < 3; n++) begin
            ctl.send({12'h000, 16'h09CF, n == 1 ? 4'h6 : 4'h4}, 23 + n);
            settle();
            chkv("gain", 3'h4, if_gain_step_r);
        end
        wr(tmcr_pkg::ADDR_OPER, 16'h09CF);
        chkv("gain", 3'h7, if_gain_step_r);
        $display("test frames done");
        report_and_stop();
    end
endmodule
`default_nettype wire
